// ### pc_stack.sv
// program counter loading and 16-entry return-address stack with apb registers
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE_01 - 15-bit pc; low byte readable and writable, upper seven come from latch.
// RULE_02 - every reset clears the whole program counter to zero.
// RULE_03 - writing the pc low byte loads pc upper bits from latch together.
// RULE_04 - direct call: operand gives low byte and bits 10:8, latch gives 14:11.
// RULE_05 - indirect call: working register gives low byte, latch gives upper bits.
// RULE_06 - register branch loads pc plus one plus unsigned working register.
// RULE_07 - immediate branch loads pc plus one plus sign-extended operand, any page.
// RULE_08 - sixteen entry, fifteen bit stack outside program and data spaces.
// RULE_09 - calls and interrupt vectoring push pc; all returns pop it.
// RULE_10 - push and pop never change the high-byte latch.
// RULE_11 - with reset option clear the stack wraps circularly over sixteen entries.
// RULE_12 - overflow and underflow flags set whether or not reset option is on.
// RULE_13 - top-of-stack pair reads and writes the entry the pointer selects.
// RULE_14 - five-bit pointer resets to 1F as empty; first push gives 00.
// RULE_15 - push increments pointer then writes; pop reads then decrements pointer.
// RULE_16 - with reset option set, overflow or underflow requests a device reset.
// RULE_17 - stack error reset option is a single bit at position nine.
// RULE_18 - seven-bit writable latch only reaches pc on a loading event.
module pc_stack (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [13:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        op_valid_i,
    input  wire logic [3:0]  op_i,
    input  wire logic [10:0] operand_i,
    input  wire logic [7:0]  working_i,
    input  wire logic [7:0]  pc_low_data_i,
    output logic      [14:0] pc_o,
    output logic             stack_reset_req_o,
    output logic             irq_o
);
    logic [14:0] pc_q;
    logic [6:0]  pc_high_latch_q;
    logic [4:0]  sp_q;
    logic [14:0] stack_q [pc_stack_pkg::STACK_DEPTH];
    logic [7:0]  copy_q [8];
    logic [31:0] config_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        stack_reset_q;
    logic        irq_q;

    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic        is_push;
    logic        is_pop;
    logic        overflow;
    logic        underflow;
    logic        opt_reset;
    logic [4:0]  sp_push;
    logic [3:0]  top_idx;
    logic [14:0] pc_next1;
    logic [14:0] branch_imm;
    logic [14:0] top_entry;
    logic [2:0]  copy_idx;

    // one wait state; read data is registered ahead, writes commit on the ready edge
    assign wr_en = psel_i && penable_i && pready_q && pwrite_i;
    assign rd_en = psel_i && penable_i && !pready_q && !pwrite_i;

    assign opt_reset = config_q[pc_stack_pkg::CFG_STACK_RESET_BIT]; // see RULE_17
    assign is_push = op_valid_i && (op_i == pc_stack_pkg::OP_CALL
                     || op_i == pc_stack_pkg::OP_CALL_IND
                     || op_i == pc_stack_pkg::OP_IRQ_VECTOR); // see RULE_09
    assign is_pop = op_valid_i && op_i == pc_stack_pkg::OP_RETURN; // see RULE_09
    assign sp_push = (sp_q == pc_stack_pkg::SP_EMPTY) ? 5'h00 : sp_q + 5'h01; // see RULE_14
    assign overflow = is_push && sp_q == 5'h0F; // see RULE_12
    assign underflow = is_pop && sp_q == pc_stack_pkg::SP_EMPTY; // see RULE_12
    assign top_idx = sp_q[3:0];
    assign top_entry = stack_q[top_idx]; // see RULE_13
    assign copy_idx = 3'(paddr_i[13:2] - pc_stack_pkg::IDX_STATUS_COPY);
    assign pc_next1 = pc_q + 15'h0001;
    assign branch_imm = pc_next1 + {{4{operand_i[10]}}, operand_i}; // see RULE_07

    always_comb begin
        mapped = 1'b1;
        unique case (paddr_i)
            pc_stack_pkg::ADDR_STATUS_COPY, pc_stack_pkg::ADDR_WORKING_COPY,
            pc_stack_pkg::ADDR_BANK_COPY, pc_stack_pkg::ADDR_LATCH_COPY,
            pc_stack_pkg::ADDR_PTR0L_COPY, pc_stack_pkg::ADDR_PTR0H_COPY,
            pc_stack_pkg::ADDR_PTR1L_COPY, pc_stack_pkg::ADDR_PTR1H_COPY,
            pc_stack_pkg::ADDR_STACK_INDEX, pc_stack_pkg::ADDR_STACK_TOP_LO,
            pc_stack_pkg::ADDR_STACK_TOP_HI, pc_stack_pkg::ADDR_PC_LOW,
            pc_stack_pkg::ADDR_PC_LATCH, pc_stack_pkg::ADDR_CONFIG,
            pc_stack_pkg::ADDR_IRQ_STATUS, pc_stack_pkg::ADDR_IRQ_MASK,
            pc_stack_pkg::ADDR_PC_FULL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // program counter
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pc_q <= 15'h0000; // see RULE_02
        end else if (wr_en && paddr_i == pc_stack_pkg::ADDR_PC_LOW) begin
            pc_q <= {pc_high_latch_q, pwdata_i[7:0]}; // see RULE_03
        end else if (op_valid_i) begin
            unique case (op_i)
                pc_stack_pkg::OP_INCREMENT: pc_q <= pc_next1;
                pc_stack_pkg::OP_WRITE_LOW: pc_q <= {pc_high_latch_q, pc_low_data_i}; // see RULE_03
                pc_stack_pkg::OP_GOTO,
                pc_stack_pkg::OP_CALL: pc_q <= {pc_high_latch_q[6:3], operand_i}; // see RULE_04
                pc_stack_pkg::OP_CALL_IND: pc_q <= {pc_high_latch_q, working_i}; // see RULE_05
                pc_stack_pkg::OP_BRANCH_REG: pc_q <= pc_next1 + {7'h00, working_i}; // see RULE_06
                pc_stack_pkg::OP_BRANCH_IMM: pc_q <= branch_imm; // see RULE_07
                pc_stack_pkg::OP_RETURN: pc_q <= top_entry; // see RULE_15
                pc_stack_pkg::OP_IRQ_VECTOR: pc_q <= {4'h0, operand_i};
                default: pc_q <= pc_q;
            endcase
        end
    end

    // high-byte latch, written only by software; stack traffic leaves it alone
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pc_high_latch_q <= 7'h00;
        end else if (wr_en && paddr_i == pc_stack_pkg::ADDR_PC_LATCH) begin
            pc_high_latch_q <= pwdata_i[6:0]; // see RULE_18 see RULE_10
        end
    end

    // stack pointer
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sp_q <= pc_stack_pkg::SP_EMPTY; // see RULE_14
        end else if (is_push) begin
            sp_q <= (sp_q == 5'h0F) ? 5'h10 : sp_push; // see RULE_15
        end else if (is_pop) begin
            sp_q <= sp_q - 5'h01; // see RULE_15
        end else if (wr_en && paddr_i == pc_stack_pkg::ADDR_STACK_INDEX) begin
            sp_q <= pwdata_i[4:0];
        end
    end

    // stack storage, circular over the low four pointer bits
    genvar gi;
    generate
        for (gi = 0; gi < pc_stack_pkg::STACK_DEPTH; gi++) begin : g_entry
            always_ff @(posedge ref_clk_i) begin
                if (is_push && sp_push[3:0] == 4'(gi)) begin
                    stack_q[gi] <= pc_next1; // see RULE_08 see RULE_11 see RULE_15
                end else if (wr_en && top_idx == 4'(gi)
                             && paddr_i == pc_stack_pkg::ADDR_STACK_TOP_LO) begin
                    stack_q[gi] <= {stack_q[gi][14:8], pwdata_i[7:0]}; // see RULE_13
                end else if (wr_en && top_idx == 4'(gi)
                             && paddr_i == pc_stack_pkg::ADDR_STACK_TOP_HI) begin
                    stack_q[gi] <= {pwdata_i[6:0], stack_q[gi][7:0]}; // see RULE_13
                end
            end
        end
    endgenerate

    // shadow copies: plain storage
    generate
        for (gi = 0; gi < 8; gi++) begin : g_copy
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    copy_q[gi] <= 8'h00;
                end else if (wr_en && paddr_i == pc_stack_pkg::ADDR_STATUS_COPY + 14'(gi * 4)) begin
                    copy_q[gi] <= pwdata_i[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            config_q <= pc_stack_pkg::CONFIG_RESET;
            mask_q   <= 2'b00;
        end else if (wr_en && paddr_i == pc_stack_pkg::ADDR_CONFIG) begin
            config_q <= pwdata_i;
        end else if (wr_en && paddr_i == pc_stack_pkg::ADDR_IRQ_MASK) begin
            mask_q <= pwdata_i[1:0];
        end
    end

    // sticky flags: hardware set wins over write-one-to-clear
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            status_q <= 2'b00;
        end else begin
            status_q <= (status_q & ~((wr_en && paddr_i == pc_stack_pkg::ADDR_IRQ_STATUS)
                         ? pwdata_i[1:0] : 2'b00)) | {underflow, overflow}; // see RULE_12
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            stack_reset_q <= 1'b0;
            irq_q         <= 1'b0;
        end else begin
            stack_reset_q <= opt_reset && (overflow || underflow); // see RULE_16
            irq_q         <= |(status_q & mask_q);
        end
    end

    // apb read and handshake
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel_i && penable_i && !pready_q;
            pslverr_q <= psel_i && penable_i && !pready_q && !mapped;
            if (rd_en) begin
                unique case (paddr_i)
                    pc_stack_pkg::ADDR_STACK_INDEX:  prdata_q <= {27'h0, sp_q};
                    pc_stack_pkg::ADDR_STACK_TOP_LO: prdata_q <= {24'h0, top_entry[7:0]};
                    pc_stack_pkg::ADDR_STACK_TOP_HI: prdata_q <= {25'h0, top_entry[14:8]};
                    pc_stack_pkg::ADDR_PC_LOW:       prdata_q <= {24'h0, pc_q[7:0]}; // see RULE_01
                    pc_stack_pkg::ADDR_PC_LATCH:     prdata_q <= {25'h0, pc_high_latch_q};
                    pc_stack_pkg::ADDR_CONFIG:       prdata_q <= config_q;
                    pc_stack_pkg::ADDR_IRQ_STATUS:   prdata_q <= {30'h0, status_q};
                    pc_stack_pkg::ADDR_IRQ_MASK:     prdata_q <= {30'h0, mask_q};
                    pc_stack_pkg::ADDR_PC_FULL:      prdata_q <= {17'h0, pc_q};
                    default: begin
                        if (paddr_i >= pc_stack_pkg::ADDR_STATUS_COPY
                            && paddr_i <= pc_stack_pkg::ADDR_PTR1H_COPY
                            && paddr_i[1:0] == 2'h0) begin
                            prdata_q <= {24'h0, copy_q[copy_idx]};
                        end else begin
                            prdata_q <= 32'h0000_0000;
                        end
                    end
                endcase
            end
        end
    end

    assign prdata_o          = prdata_q;
    assign pready_o          = pready_q;
    assign pslverr_o         = pslverr_q;
    assign pc_o              = pc_q;
    assign stack_reset_req_o = stack_reset_q;
    assign irq_o             = irq_q;
endmodule : pc_stack

`default_nettype wire

// ### pc_stack_pkg.sv
// constants for the program counter and return-address stack block
package pc_stack_pkg;
    localparam int PC_WIDTH     = 15;
    localparam int STACK_DEPTH  = 16;
    localparam int SP_WIDTH     = 5;
    localparam logic [4:0] SP_EMPTY = 5'h1F;

    // register indexes; every register is one word, its byte address is four times the index
    localparam logic [11:0] IDX_STATUS_COPY   = 12'hFE4;
    localparam logic [11:0] IDX_WORKING_COPY  = 12'hFE5;
    localparam logic [11:0] IDX_BANK_COPY     = 12'hFE6;
    localparam logic [11:0] IDX_LATCH_COPY    = 12'hFE7;
    localparam logic [11:0] IDX_PTR0L_COPY    = 12'hFE8;
    localparam logic [11:0] IDX_PTR0H_COPY    = 12'hFE9;
    localparam logic [11:0] IDX_PTR1L_COPY    = 12'hFEA;
    localparam logic [11:0] IDX_PTR1H_COPY    = 12'hFEB;
    localparam logic [11:0] IDX_STACK_INDEX   = 12'hFED;
    localparam logic [11:0] IDX_STACK_TOP_LO  = 12'hFEE;
    localparam logic [11:0] IDX_STACK_TOP_HI  = 12'hFEF;

    // byte addresses over the register bus
    localparam logic [13:0] ADDR_STATUS_COPY  = {IDX_STATUS_COPY, 2'h0};
    localparam logic [13:0] ADDR_WORKING_COPY = {IDX_WORKING_COPY, 2'h0};
    localparam logic [13:0] ADDR_BANK_COPY    = {IDX_BANK_COPY, 2'h0};
    localparam logic [13:0] ADDR_LATCH_COPY   = {IDX_LATCH_COPY, 2'h0};
    localparam logic [13:0] ADDR_PTR0L_COPY   = {IDX_PTR0L_COPY, 2'h0};
    localparam logic [13:0] ADDR_PTR0H_COPY   = {IDX_PTR0H_COPY, 2'h0};
    localparam logic [13:0] ADDR_PTR1L_COPY   = {IDX_PTR1L_COPY, 2'h0};
    localparam logic [13:0] ADDR_PTR1H_COPY   = {IDX_PTR1H_COPY, 2'h0};
    localparam logic [13:0] ADDR_STACK_INDEX  = {IDX_STACK_INDEX, 2'h0};
    localparam logic [13:0] ADDR_STACK_TOP_LO = {IDX_STACK_TOP_LO, 2'h0};
    localparam logic [13:0] ADDR_STACK_TOP_HI = {IDX_STACK_TOP_HI, 2'h0};
    localparam logic [13:0] ADDR_PC_LOW       = 14'h0F00;
    localparam logic [13:0] ADDR_PC_LATCH     = 14'h0F04;
    localparam logic [13:0] ADDR_CONFIG       = 14'h0F08;
    localparam logic [13:0] ADDR_IRQ_STATUS   = 14'h0F0C;
    localparam logic [13:0] ADDR_IRQ_MASK     = 14'h0F10;
    localparam logic [13:0] ADDR_PC_FULL      = 14'h0F14;

    // config register bit: stack error reset option
    localparam int CFG_STACK_RESET_BIT = 9;
    // status bit positions
    localparam int ST_OVERFLOW  = 0;
    localparam int ST_UNDERFLOW = 1;

    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    // core operations
    typedef enum logic [3:0] {
        OP_NONE        = 4'h0,
        OP_INCREMENT   = 4'h1,
        OP_WRITE_LOW   = 4'h2,
        OP_CALL        = 4'h3,
        OP_CALL_IND    = 4'h4,
        OP_BRANCH_REG  = 4'h5,
        OP_BRANCH_IMM  = 4'h6,
        OP_RETURN      = 4'h7,
        OP_IRQ_VECTOR  = 4'h8,
        OP_GOTO        = 4'h9
    } op_type;
endpackage : pc_stack_pkg

// ### pc_stack_props.sv
// concurrent checks on the ports of the pc and return-address stack block
`timescale 1ns/100ps
`default_nettype none
module pc_stack_props (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        op_valid_i,
    input wire logic [3:0]  op_i,
    input wire logic [10:0] operand_i,
    input wire logic [7:0]  working_i,
    input wire logic [7:0]  pc_low_data_i,
    input wire logic [14:0] pc_o,
    input wire logic        stack_reset_req_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_op(logic [3:0] o);
        op_valid_i && op_i == o;
    endsequence
    sequence s_acc;
        psel_i && $rose(penable_i);
    endsequence
    property p_reset_pc;
        @(posedge ref_clk_i) disable iff (1'b0) reset_i |=> pc_o == 15'h0000;
    endproperty
    property p_write_low;
        s_op(pc_stack_pkg::OP_WRITE_LOW) |=> pc_o[7:0] == $past(pc_low_data_i);
    endproperty
    property p_call;
        s_op(pc_stack_pkg::OP_CALL) |=> pc_o[10:0] == $past(operand_i);
    endproperty
    property p_call_ind;
        s_op(pc_stack_pkg::OP_CALL_IND) |=> pc_o[7:0] == $past(working_i);
    endproperty
    property p_br_reg;
        s_op(pc_stack_pkg::OP_BRANCH_REG) |=> pc_o == $past(pc_o) + 15'h0001 + $past(working_i);
    endproperty
    property p_br_imm;
        s_op(pc_stack_pkg::OP_BRANCH_IMM) |=>
            pc_o == $past(pc_o) + 15'h0001 + {{4{$past(operand_i[10])}}, $past(operand_i)};
    endproperty
    property p_hold;
        !op_valid_i && !psel_i |=> $stable(pc_o);
    endproperty
    property p_answer;
        s_acc |=> pready_o;
    endproperty
    property p_err;
        pslverr_o |-> pready_o;
    endproperty
    property p_req_pulse;
        stack_reset_req_o |=> !stack_reset_req_o;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc not cleared");
    a_write_low: assert property (p_write_low) else $error("low byte load");
    a_call: assert property (p_call) else $error("call target");
    a_call_ind: assert property (p_call_ind) else $error("indirect call target");
    a_br_reg: assert property (p_br_reg) else $error("register branch");
    a_br_imm: assert property (p_br_imm) else $error("immediate branch");
    a_hold: assert property (p_hold) else $error("pc moved while idle");
    a_answer: assert property (p_answer) else $error("late bus answer");
    a_err: assert property (p_err) else $error("error without ready");
    a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
endmodule : pc_stack_props
bind pc_stack pc_stack_props props (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .op_valid_i(op_valid_i),
    .op_i(op_i), .operand_i(operand_i), .working_i(working_i), .pc_low_data_i(pc_low_data_i),
    .pc_o(pc_o), .stack_reset_req_o(stack_reset_req_o));
`default_nettype wire

// ### core_model.sv
// core decode model issuing one pc operation at a time
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input  wire logic        ref_clk_i,
    output logic             op_valid_o,
    output logic      [3:0]  op_o,
    output logic      [10:0] operand_o,
    output logic      [7:0]  working_o,
    output logic      [7:0]  pc_low_data_o
);
    initial begin
        op_valid_o = 1'b0;
        op_o = 4'h0;
        operand_o = 11'h000;
        working_o = 8'h00;
        pc_low_data_o = 8'h00;
    end
    task automatic issue(input logic [3:0] o, input logic [10:0] d, input logic [7:0] w);
        @(posedge ref_clk_i);
        op_valid_o <= 1'b1;
        op_o <= o;
        operand_o <= d;
        working_o <= w;
        pc_low_data_o <= w;
        @(posedge ref_clk_i);
        // idle fields flip so stale values are never trusted
        op_valid_o <= 1'b0;
        operand_o <= ~d;
        working_o <= ~w;
        pc_low_data_o <= ~w;
        #1;
    endtask : issue
endmodule : core_model
`default_nettype wire

// ### pc_stack_test.sv
// self-checking bench for the pc and return-address stack block
`timescale 1ns/100ps
`default_nettype none
module pc_stack_test;
    logic        ref_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic        op_valid_i, stack_reset_req_o, irq_o;
    logic [13:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0]  op_i;
    logic [10:0] operand_i;
    logic [7:0]  working_i, pc_low_data_i;
    logic [14:0] pc_o, exp_pc, ret;
    int          n_mismatch, cmp_count, n_req;
    pc_stack DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .op_valid_i(op_valid_i), .op_i(op_i), .operand_i(operand_i), .working_i(working_i),
        .pc_low_data_i(pc_low_data_i), .pc_o(pc_o), .stack_reset_req_o(stack_reset_req_o),
        .irq_o(irq_o));
    core_model core (.ref_clk_i(ref_clk_i), .op_valid_o(op_valid_i), .op_o(op_i),
        .operand_o(operand_i), .working_o(working_i), .pc_low_data_o(pc_low_data_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        #1;
        chk(n < 20, 1'b1);
    endtask : apb
    task automatic rdchk(input logic [13:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk
    task automatic run(input logic [3:0] o, input logic [10:0] d, input logic [7:0] w,
                       input logic [14:0] e);
        core.issue(o, d, w);
        exp_pc = e;
        chk(pc_o, e);
    endtask : run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) if (stack_reset_req_o === 1'b1) n_req++;
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        reset_i = 1'b1;
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        chk(pc_o, 15'h0000);
        rdchk(pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_001F);
        rdchk(pc_stack_pkg::ADDR_CONFIG, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            rdchk(pc_stack_pkg::ADDR_STATUS_COPY + 14'(4 * i), 32'h0000_0000);
            apb(1'b1, pc_stack_pkg::ADDR_STATUS_COPY + 14'(4 * i), 32'h0000_00A0 + i);
            rdchk(pc_stack_pkg::ADDR_STATUS_COPY + 14'(4 * i), 32'h0000_00A0 + i);
        end
        apb(1'b0, 14'h3FB0, 32'h0000_0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, pc_stack_pkg::ADDR_PC_LATCH, 32'h0000_007F);
        chk(pc_o, 15'h0000);
        run(pc_stack_pkg::OP_WRITE_LOW, 11'h000, 8'h34, 15'h7F34);
        apb(1'b1, pc_stack_pkg::ADDR_PC_LATCH, 32'h0000_0055);
        run(pc_stack_pkg::OP_CALL, 11'h123, 8'h00, 15'h5123);
        rdchk(pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_0000);
        rdchk(pc_stack_pkg::ADDR_STACK_TOP_LO, 32'h0000_0035);
        rdchk(pc_stack_pkg::ADDR_STACK_TOP_HI, 32'h0000_007F);
        rdchk(pc_stack_pkg::ADDR_PC_LATCH, 32'h0000_0055);
        run(pc_stack_pkg::OP_CALL_IND, 11'h000, 8'h9A, 15'h559A);
        run(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00, 15'h5124);
        rdchk(pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_0000);
        run(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00, 15'h7F35);
        run(pc_stack_pkg::OP_BRANCH_REG, 11'h000, 8'hFF, exp_pc + 15'h0100);
        run(pc_stack_pkg::OP_BRANCH_IMM, 11'h7F0, 8'h00, exp_pc - 15'h000F);
        run(pc_stack_pkg::OP_BRANCH_IMM, 11'h3FF, 8'h00, exp_pc + 15'h0400);
        run(pc_stack_pkg::OP_INCREMENT, 11'h000, 8'h00, exp_pc + 15'h0001);
        ret = exp_pc + 15'h0001;
        run(pc_stack_pkg::OP_IRQ_VECTOR, 11'h004, 8'h00, 15'h0004);
        run(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00, ret);
        apb(1'b1, pc_stack_pkg::ADDR_PC_LOW, 32'h0000_0012);
        chk(pc_o, 15'h5512);
        rdchk(pc_stack_pkg::ADDR_PC_FULL, 32'h0000_5512);
        run(pc_stack_pkg::OP_GOTO, 11'h2AB, 8'h00, 15'h52AB);
        run(pc_stack_pkg::OP_NONE, 11'h000, 8'h00, 15'h52AB);
        rdchk(pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_001F);
        apb(1'b1, pc_stack_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
        for (int i = 0; i < 17; i++)
            run(pc_stack_pkg::OP_CALL, 11'(i), 8'h00, {4'hA, 11'(i)});
        rdchk(pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_0010);
        rdchk(pc_stack_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
        chk(irq_o, 1'b1);
        apb(1'b1, pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_0000);
        rdchk(pc_stack_pkg::ADDR_STACK_TOP_LO, 32'h0000_0010);
        rdchk(pc_stack_pkg::ADDR_STACK_TOP_HI, 32'h0000_0050);
        apb(1'b1, pc_stack_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
        apb(1'b1, pc_stack_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        chk(irq_o, 1'b0);
        apb(1'b1, pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_001F);
        core.issue(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00);
        rdchk(pc_stack_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
        chk(irq_o, 1'b0);
        chk(n_req, 0);
        apb(1'b1, pc_stack_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
        apb(1'b1, pc_stack_pkg::ADDR_CONFIG, 32'h0000_0200);
        chk(irq_o, 1'b1);
        rdchk(pc_stack_pkg::ADDR_CONFIG, 32'h0000_0200);
        apb(1'b1, pc_stack_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
        apb(1'b1, pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_001F);
        core.issue(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00);
        repeat (3) @(posedge ref_clk_i);
        chk(n_req, 1);
        rdchk(pc_stack_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        chk(pc_o, 15'h0000);
        rdchk(pc_stack_pkg::ADDR_STACK_INDEX, 32'h0000_001F);
        rdchk(pc_stack_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : pc_stack_test
`default_nettype wire
